// File: rtl/position_node_defines.svh
// constants for the position node sequencer
// Function
// - mode field picks absolute, relative or incremental target
// - interrupt node aborts the node now executing
// - flow: next command loads after present node finishes
// - flow: next command is node triggered while running
// - automatic: start next numbered node after completion
// - interrupt outranks all, replaces target at once
// - flow pending node starts after completion and dwell
// - flow without insertion falls back to automatic check
// - automatic advance only without queued or interrupting node
// - interrupt trigger pre-empts an automatic node
// - non-interrupt trigger during automatic node without flow is discarded
// - no flow, no automatic: reject non-interrupt triggers
// - no flow, no automatic: accept triggers after finish
`ifndef POSITION_NODE_DEFINES_SVH
`define POSITION_NODE_DEFINES_SVH
`define NODE_COUNT 32
`define NODE_IDX_W 5
`define POS_W 32
`define DWELL_W 16
`define NODE_FIRST 5'h00
`define NODE_LAST 5'h1F
`define NODE_STEP 5'h01
`define MODE_ABS 2'h0
`define MODE_REL 2'h1
`define MODE_INC 2'h2
`define DWELL_ZERO 16'h0000
`define DWELL_STEP 16'h0001
`define POS_RESET 32'h00000000
`endif

// File: rtl/position_node_pkg.sv
// types shared by the position node sequencer files
`include "position_node_defines.svh"
package position_node_pkg;
  // per-node attribute flags and reference mode
  typedef struct packed {
    logic interrupt_attr;
    logic flow_attr;
    logic sequential_advance_flag;
    logic [1:0] ref_mode;
  } node_attr_t;
  // one stored node: attributes, position command, dwell in clocks
  typedef struct packed {
    node_attr_t attr;
    logic signed [`POS_W-1:0] cmd;
    logic [`DWELL_W-1:0] dwell;
  } node_cfg_t;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DWELL
  } seq_state_t;
endpackage

// File: rtl/position_node_sequencer.sv
// scheduler choosing how stored position nodes follow one another
`timescale 1ns/10ps
`include "position_node_defines.svh"
module position_node_sequencer
  import position_node_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // node table write port
  input wire logic cfg_we,
  input wire logic [`NODE_IDX_W-1:0] cfg_idx,
  input wire position_node_pkg::node_cfg_t cfg_data,
  // trigger from master controller
  input wire logic trig_valid,
  input wire logic [`NODE_IDX_W-1:0] trig_node,
  // trajectory planner feedback
  input wire logic signed [`POS_W-1:0] motor_pos,
  input wire logic move_done,
  // commands to trajectory planner
  output logic move_start,
  output logic move_abort,
  output logic signed [`POS_W-1:0] target_pos,
  // status
  output logic [`NODE_IDX_W-1:0] run_node,
  output logic busy,
  output logic trig_discard
);
  import position_node_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // node table
  node_cfg_t node_mem [`NODE_COUNT]; // stored nodes, no reset: data only

  // table write, software keeps writes away from running nodes
  always_ff @(posedge clk) begin
    if (cfg_we) begin
      node_mem[cfg_idx] <= cfg_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // state
  seq_state_t state_reg, state_next; // sequencer state
  logic [`NODE_IDX_W-1:0] cur_reg, cur_next; // executing node
  logic pend_reg, pend_next; // flow follow-on queued
  logic [`NODE_IDX_W-1:0] pend_node_reg, pend_node_next; // queued node
  logic [`DWELL_W-1:0] dwell_reg, dwell_next; // dwell countdown
  logic signed [`POS_W-1:0] tgt_reg, tgt_next; // present target
  logic start_reg, start_next; // load pulse
  logic abort_reg, abort_next; // abort pulse
  logic disc_reg, disc_next; // discard pulse

  // combinational helpers
  node_cfg_t trig_cfg; // attributes of triggered node
  node_cfg_t cur_cfg; // attributes of executing node
  node_cfg_t load_cfg; // node chosen for loading
  logic trig_ok; // usable trigger, node zero never runs
  logic irq_hit; // interrupt trigger while busy
  logic load_en; // load a node this cycle
  logic [`NODE_IDX_W-1:0] load_idx; // which node loads
  logic signed [`POS_W-1:0] load_target; // its formed target

  // true when a node advances to a further numbered node
  function automatic logic has_successor(input node_cfg_t cfg,
                                         input logic [`NODE_IDX_W-1:0] idx);
    has_successor = cfg.attr.sequential_advance_flag && (idx != `NODE_LAST);
  endfunction

  assign trig_cfg = node_mem[trig_node];
  assign cur_cfg = node_mem[cur_reg];
  assign load_cfg = node_mem[load_idx];
  assign trig_ok = trig_valid && (trig_node != `NODE_FIRST);
  assign irq_hit = trig_ok && (state_reg != ST_IDLE) && trig_cfg.attr.interrupt_attr;

  // target formation for the node about to load
  target_former former_u (
    .ref_mode(load_cfg.attr.ref_mode),
    .cmd(load_cfg.cmd),
    .motor_pos(motor_pos),
    .prev_target(tgt_reg),
    .target(load_target)
  );

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    state_next = state_reg;
    cur_next = cur_reg;
    pend_next = pend_reg;
    pend_node_next = pend_node_reg;
    dwell_next = dwell_reg;
    tgt_next = tgt_reg;
    abort_next = 1'b0;
    disc_next = 1'b0;
    load_en = 1'b0;
    load_idx = cur_reg;
    if (state_reg == ST_IDLE) begin
      // idle: any usable trigger starts at once
      if (trig_ok) begin
        load_en = 1'b1;
        load_idx = trig_node;
      end
    end else if (irq_hit) begin
      // interrupt checked first so it beats any queued node
      abort_next = 1'b1;
      load_en = 1'b1;
      load_idx = trig_node;
      pend_next = 1'b0;
    end else begin
      // non-interrupt trigger: queue under flow, else throw away
      if (trig_ok) begin
        if (cur_cfg.attr.flow_attr) begin
          pend_next = 1'b1;
          pend_node_next = trig_node;
        end else begin
          disc_next = 1'b1;
        end
      end
      case (state_reg)
        ST_RUN: begin
          // wait for the planner to finish the present node
          if (move_done) begin
            state_next = ST_DWELL;
            dwell_next = cur_cfg.dwell;
          end
        end
        ST_DWELL: begin
          if (dwell_reg != `DWELL_ZERO) begin
            dwell_next = dwell_reg - `DWELL_STEP;
          end else if (pend_next) begin
            // a queued node takes over only after the dwell
            load_en = 1'b1;
            load_idx = pend_node_next;
            pend_next = 1'b0;
          end else if (has_successor(cur_cfg, cur_reg)) begin
            // no insertion: fall back to sequential advance
            load_en = 1'b1;
            load_idx = cur_reg + `NODE_STEP;
          end else begin
            state_next = ST_IDLE;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    // a load always starts a fresh run
    if (load_en) begin
      state_next = ST_RUN;
      cur_next = load_idx;
      tgt_next = load_target;
    end
    start_next = load_en;
  end

  ////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cur_reg <= `NODE_FIRST;
      pend_reg <= 1'b0;
      pend_node_reg <= `NODE_FIRST;
      dwell_reg <= `DWELL_ZERO;
      tgt_reg <= `POS_RESET;
      start_reg <= 1'b0;
      abort_reg <= 1'b0;
      disc_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cur_reg <= cur_next;
      pend_reg <= pend_next;
      pend_node_reg <= pend_node_next;
      dwell_reg <= dwell_next;
      tgt_reg <= tgt_next;
      start_reg <= start_next;
      abort_reg <= abort_next;
      disc_reg <= disc_next;
    end
  end

  // outputs straight from flops, busy decoded from state_reg
  assign move_start = start_reg;
  assign move_abort = abort_reg;
  assign target_pos = tgt_reg;
  assign run_node = cur_reg;
  assign busy = (state_reg != ST_IDLE);
  assign trig_discard = disc_reg;

  ////////////////////////////////////////////////////////////////////
  // assertions
  logic dwell_end; // dwell finished this cycle
  logic nonirq_trig; // usable trigger lacking interrupt
  assign dwell_end = (state_reg == ST_DWELL) && (dwell_reg == `DWELL_ZERO) && !irq_hit;
  assign nonirq_trig = trig_ok && !trig_cfg.attr.interrupt_attr;

  property p_abs_target;
    @(posedge clk) disable iff (sys_rst)
    load_en && (load_cfg.attr.ref_mode == `MODE_ABS) |=> target_pos == $past(load_cfg.cmd);
  endproperty
  a_abs_target: assert property (p_abs_target) else $error("absolute target wrong");

  property p_inc_target;
    @(posedge clk) disable iff (sys_rst)
    load_en && (load_cfg.attr.ref_mode == `MODE_INC)
      |=> target_pos == $past(tgt_reg) + $past(load_cfg.cmd);
  endproperty
  a_inc_target: assert property (p_inc_target) else $error("incremental target wrong");

  property p_irq_preempt;
    @(posedge clk) disable iff (sys_rst)
    irq_hit |=> move_abort && move_start && run_node == $past(trig_node) && !pend_reg;
  endproperty
  a_irq_preempt: assert property (p_irq_preempt) else $error("interrupt not taken");

  property p_irq_over_auto;
    @(posedge clk) disable iff (sys_rst)
    irq_hit && cur_cfg.attr.sequential_advance_flag |=> move_abort ##0 busy;
  endproperty
  a_irq_over_auto: assert property (p_irq_over_auto) else $error("auto not pre-empted");

  property p_flow_holds;
    @(posedge clk) disable iff (sys_rst)
    (state_reg == ST_RUN) && !move_done && !irq_hit |=> !move_start;
  endproperty
  a_flow_holds: assert property (p_flow_holds) else $error("load while running");

  property p_flow_queue;
    @(posedge clk) disable iff (sys_rst)
    // a flow trigger in the closing dwell cycle loads at once instead of queuing
    busy && !irq_hit && !dwell_end && nonirq_trig && cur_cfg.attr.flow_attr
      |=> pend_reg && pend_node_reg == $past(trig_node) && !trig_discard;
  endproperty
  a_flow_queue: assert property (p_flow_queue) else $error("flow node not queued");

  property p_flow_load;
    @(posedge clk) disable iff (sys_rst)
    dwell_end && pend_reg && !trig_ok |=> move_start && run_node == $past(pend_node_reg);
  endproperty
  a_flow_load: assert property (p_flow_load) else $error("queued node not loaded");

  property p_auto_step;
    @(posedge clk) disable iff (sys_rst)
    dwell_end && !pend_reg && !trig_ok && has_successor(cur_cfg, cur_reg)
      |=> move_start && run_node == $past(cur_reg) + `NODE_STEP;
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("no sequential advance");

  property p_discard;
    @(posedge clk) disable iff (sys_rst)
    busy && nonirq_trig && !cur_cfg.attr.flow_attr |=> trig_discard && !move_abort;
  endproperty
  a_discard: assert property (p_discard) else $error("trigger not discarded");

  property p_idle_return;
    @(posedge clk) disable iff (sys_rst)
    dwell_end && !pend_reg && !trig_ok && !has_successor(cur_cfg, cur_reg)
      |=> !busy ##1 (!busy || move_start);
  endproperty
  a_idle_return: assert property (p_idle_return) else $error("no return to idle");

  property p_irq_beats_flow;
    @(posedge clk) disable iff (sys_rst)
    irq_hit && trig_cfg.attr.flow_attr |=> move_start && !pend_reg;
  endproperty
  a_irq_beats_flow: assert property (p_irq_beats_flow) else $error("priority broken");

  c_preempt: cover property (@(posedge clk) disable iff (sys_rst) irq_hit);
  c_flow_chain: cover property (@(posedge clk) disable iff (sys_rst) dwell_end && pend_reg);
  c_auto_chain: cover property (@(posedge clk) disable iff (sys_rst)
    dwell_end && !pend_reg && has_successor(cur_cfg, cur_reg));
  c_discard: cover property (@(posedge clk) disable iff (sys_rst) trig_discard);
endmodule

// File: rtl/target_former.sv
// forms a node's target position from its reference mode
`timescale 1ns/10ps
`include "position_node_defines.svh"
module target_former (
  // node command
  input wire logic [1:0] ref_mode,
  input wire logic signed [`POS_W-1:0] cmd,
  // position context
  input wire logic signed [`POS_W-1:0] motor_pos,
  input wire logic signed [`POS_W-1:0] prev_target,
  // result
  output logic signed [`POS_W-1:0] target
);
  // unknown mode codes fall back to absolute, the safest reading
  always_comb begin
    case (ref_mode)
      `MODE_REL: target = motor_pos + cmd;
      `MODE_INC: target = prev_target + cmd;
      default: target = cmd;
    endcase
  end
endmodule

// File: tb/planner_model.sv
// trajectory planner stand-in: answers the latest move start with a done pulse
`timescale 1ns/10ps
module planner_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // move start from the sequencer, move length from the bench
  input wire logic move_start,
  input wire logic [7:0] latency,
  // feedback to the sequencer
  output logic move_done
);
  logic [7:0] cnt_reg; // cycles left of the present move
  logic [7:0] cnt_next;
  logic done_next;
  ////////////////////////////////////////////////////////////////
  // a new start restarts the count, so an aborted move leaves no stale done
  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (move_start) begin
      cnt_next = latency;
    end else if (cnt_reg == 8'h01) begin
      cnt_next = 8'h00;
      done_next = 1'b1;
    end else if (cnt_reg != 8'h00) begin
      cnt_next = cnt_reg - 8'h01;
    end
  end
  // registers only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 8'h00;
      move_done <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      move_done <= done_next;
    end
  end
endmodule

// File: tb/position_node_sequencer_tb.sv
// self-checking bench for the position node sequencer
`timescale 1ns/10ps
`include "position_node_defines.svh"
module position_node_sequencer_tb;
  import position_node_pkg::*;
  logic clk = 1'b0; // 250 MHz
  logic sys_rst = 1'b1;
  logic cfg_we = 1'b0;
  logic [`NODE_IDX_W-1:0] cfg_idx = 5'h00;
  node_cfg_t cfg_data = '0;
  logic trig_valid = 1'b0;
  logic [`NODE_IDX_W-1:0] trig_node = 5'h00;
  logic signed [`POS_W-1:0] motor_pos = 32'h00001000; // fixed motor position
  logic [7:0] lat = 8'h14; // planner move length
  logic move_done, move_start, move_abort, busy, trig_discard;
  logic signed [`POS_W-1:0] target_pos;
  logic [`NODE_IDX_W-1:0] run_node;
  int fail_count = 0;
  int checks = 0;
  int n;
  ////////////////////////////////////////////////////////////////
  position_node_sequencer i_dut (.clk(clk), .sys_rst(sys_rst), .cfg_we(cfg_we),
    .cfg_idx(cfg_idx), .cfg_data(cfg_data), .trig_valid(trig_valid), .trig_node(trig_node),
    .motor_pos(motor_pos), .move_done(move_done), .move_start(move_start),
    .move_abort(move_abort), .target_pos(target_pos), .run_node(run_node), .busy(busy),
    .trig_discard(trig_discard));
  planner_model i_planner (.clk(clk), .sys_rst(sys_rst), .move_start(move_start),
    .latency(lat), .move_done(move_done));
  ////////////////////////////////////////////////////////////////
  // clock
  initial begin
    forever #2 clk = ~clk;
  end
  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // verdict
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one table write: flags, mode, command, dwell
  task automatic cfg(input logic [4:0] i, input logic [4:0] a, input logic [31:0] c,
                     input logic [15:0] d);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_idx <= i;
    cfg_data <= {a, c, d};
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask
  // one-cycle trigger; answer pulses are readable on return
  task automatic trig(input logic [4:0] i);
    @(posedge clk);
    trig_valid <= 1'b1;
    trig_node <= i;
    @(posedge clk);
    trig_valid <= 1'b0;
    #1;
  endtask
  // bounded wait for the next load, n holds one less than the cycles waited
  task automatic wait_start();
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      #1;
      if (move_start === 1'b1) break;
    end
    if (n == 200) chk("start_wait", 0, 1);
  endtask
  // bounded wait for return to idle
  task automatic wait_idle();
    // busy is read 1 ns after each edge, once it has settled
    for (n = 0; n < 300 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chk("busy_idle", busy, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs well under 5000 cycles
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
  // main sequence; attribute field is irq, flow, auto, mode[1:0]
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    cfg(5'h04, 5'h08, 32'h00000064, 16'h0002);
    cfg(5'h07, 5'h01, 32'h00000005, 16'h0000);
    cfg(5'h09, 5'h12, 32'h00000003, 16'h0000);
    cfg(5'h05, 5'h04, 32'h00000032, 16'h0000);
    cfg(5'h06, 5'h00, 32'h0000003C, 16'h0000);
    cfg(5'h08, 5'h0C, 32'h00000050, 16'h0001);
    cfg(5'h1E, 5'h04, 32'h0000012C, 16'h0000);
    cfg(5'h1F, 5'h04, 32'h00000136, 16'h0000);
    // flow node with a trigger queued while it runs
    trig(5'h04);
    chk("start", move_start, 1'b1);
    chk("target", target_pos, 32'h00000064);
    trig(5'h07);
    chk("queued_start", move_start, 1'b0);
    chk("queued_discard", trig_discard, 1'b0);
    wait_start();
    chk("flow_wait", n, 32'h00000016);
    chk("flow_node", run_node, 5'h07);
    chk("rel_target", target_pos, 32'h00001005);
    wait_idle();
    // automatic node: plain trigger dropped, interrupt trigger pre-empts
    trig(5'h05);
    trig(5'h06);
    chk("auto_discard", trig_discard, 1'b1);
    trig(5'h09);
    chk("abort", move_abort, 1'b1);
    chk("irq_start", move_start, 1'b1);
    chk("inc_target", target_pos, 32'h00000035);
    wait_idle();
    // no flow, no automatic: reject until finished, then accept
    trig(5'h06);
    trig(5'h07);
    chk("plain_discard", trig_discard, 1'b1);
    wait_idle();
    trig(5'h07);
    chk("accept_after", run_node, 5'h07);
    wait_idle();
    // sequential advance, stopping at the last node
    trig(5'h1E);
    wait_start();
    chk("auto_next", run_node, 5'h1F);
    wait_idle();
    // flow and automatic together: no insertion advances, insertion wins
    trig(5'h08);
    wait_start();
    chk("flow_auto_next", run_node, 5'h09);
    chk("flow_auto_target", target_pos, 32'h00000053);
    wait_idle();
    trig(5'h08);
    trig(5'h06);
    wait_start();
    chk("queued_beats_auto", run_node, 5'h06);
    wait_idle();
    end_of_test();
  end
endmodule
